// ===== core/tag_pkg.sv
// Package: page map, config fields, resets and counts of the tag core
package tag_pkg;

    // ==========================================================
    // Page indices (one 32-bit page each)
    localparam logic [5:0] PAGE_UID_HEAD      = 6'h00;
    localparam logic [5:0] PAGE_UID_TAIL      = 6'h01;
    localparam logic [5:0] PAGE_UID_CHECK     = 6'h02;
    localparam logic [5:0] PAGE_CAPABILITY    = 6'h03;
    localparam logic [5:0] PAGE_USER_FIRST    = 6'h04;
    localparam logic [5:0] PAGE_USER_A_LAST   = 6'h0F;
    localparam logic [5:0] PAGE_USER_B_FIRST  = 6'h10;
    localparam logic [5:0] PAGE_USER_LAST     = 6'h27;
    localparam logic [5:0] PAGE_EXTRA_LOCK    = 6'h28;
    localparam logic [5:0] PAGE_CONFIG_A      = 6'h29;
    localparam logic [5:0] PAGE_CONFIG_B      = 6'h2A;
    localparam logic [5:0] PAGE_ACCESS_SECRET = 6'h2B;
    localparam logic [5:0] PAGE_ACCESS_ACK    = 6'h2C;
    localparam logic [5:0] PAGE_KEY_HIGH      = 6'h2D;
    localparam logic [5:0] PAGE_KEY_MID       = 6'h2E;
    localparam logic [5:0] PAGE_KEY_LOW       = 6'h2F;
    localparam logic [5:0] PAGE_INIT_VECTOR   = 6'h30;
    localparam logic [5:0] PAGE_TIME_STAMP    = 6'h31;
    localparam logic [5:0] PAGE_PSEUDO_RANDOM = 6'h32;
    localparam logic [5:0] PAGE_CORE_STATUS   = 6'h33;
    localparam int         NVM_PAGES          = 49;

    // ==========================================================
    // Byte lanes: byte 0 sits in bits 31:24
    localparam int TAMPER_LOW_LSB   = 16;  // config A byte 1
    localparam int DETECT_CFG_LSB   = 8;   // config B byte 2
    localparam int DYN_CFG_LSB      = 0;   // config B byte 3

    // ==========================================================
    // Field positions inside the config bytes
    localparam int PIN_FUNC_LSB     = 0;   // detect_pin_config [1:0]
    localparam int PIN_PUSHPULL_BIT = 2;   // 1: 1.8V output, 0: open drain
    localparam int ROLL_EN_BIT      = 0;   // dynamic_data_config
    localparam int MIX_EN_BIT       = 1;

    typedef enum logic [1:0] {
        PIN_OFF,
        PIN_FIELD_DETECT,
        PIN_TAMPER_DETECT,
        PIN_SLEEP_STRAP
    } pin_mode_e;

    // ==========================================================
    // Values and counts
    localparam logic [7:0]  TAMPER_OPEN   = 8'h01;
    localparam logic [7:0]  TAMPER_CLOSED = 8'h00;
    localparam logic [31:0] UID_HEAD_VAL  = 32'hA1B2_C3D4; // Arbitrary
    localparam logic [31:0] UID_TAIL_VAL  = 32'h789A_BCDE; // Arbitrary
    localparam logic [31:0] PAGE_RESET    = 32'h0000_0000;
    localparam int          WARMUP_CYCLES = 64;
    localparam int          WORD_BITS     = 32;
    localparam logic [6:0]  GEN_CYCLES    = 7'(WARMUP_CYCLES + WORD_BITS);

endpackage

// ===== core/detect_pin_port.sv
// Detect pin driver and input sampler
`timescale 1ns/10ps
`default_nettype none
module detect_pin_port
    import tag_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    // Configuration and field
    input  wire pin_mode_e  i_mode,
    input  wire logic       i_push_pull,
    input  wire logic       i_rf_field,
    // Pin
    input  wire logic       i_pin_in,
    output logic            o_pin_out,
    output logic            o_pin_oe_n,
    output logic            o_pin_level
);

    // ==========================================================
    // Output stage
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pin_out  <= 1'b0;
            o_pin_oe_n <= 1'b1;
        end else if (i_mode == PIN_FIELD_DETECT) begin
            if (i_push_pull) begin
                o_pin_out  <= i_rf_field;
                o_pin_oe_n <= 1'b0;
            end else begin
                // Pull low while a field is present
                o_pin_out  <= 1'b0;
                o_pin_oe_n <= !i_rf_field;
            end
        end else begin
            o_pin_out  <= 1'b0;
            o_pin_oe_n <= 1'b1;
        end
    end

    // ==========================================================
    // Input sample
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pin_level <= 1'b1;
        end else begin
            o_pin_level <= i_pin_in;
        end
    end

endmodule // detect_pin_port
`default_nettype wire

// ===== core/rollcode_cipher.sv
// Keyed shift-register stream generator for one pseudo-random word
`timescale 1ns/10ps
`default_nettype none
module rollcode_cipher
    import tag_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    // Request
    input  wire logic        i_start,
    input  wire logic [79:0] i_key,
    input  wire logic [31:0] i_stamp,
    input  wire logic [7:0]  i_tamper,
    input  wire logic        i_mix,
    // Answer
    output logic             o_busy,
    output logic             o_done,
    output logic [31:0]      o_word
);

    logic [79:0] state;
    logic [6:0]  count;
    logic [7:0]  salt;
    logic        feedback;

    assign salt     = i_mix ? i_tamper : 8'h00;
    assign feedback = state[79] ^ state[62] ^ state[51] ^ state[13]
                    ^ (state[70] & state[40]);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state  <= '0;
            count  <= '0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_word <= '0;
        end else begin
            o_done <= 1'b0;
            if (i_start && !o_busy) begin
                state  <= i_key ^ {i_stamp, i_stamp, salt, salt};
                count  <= '0;
                o_busy <= 1'b1;
            end else if (o_busy) begin
                state <= {state[78:0], feedback};
                count <= count + 7'h01;
                if (count >= 7'(WARMUP_CYCLES)) begin
                    o_word <= {o_word[30:0], feedback};
                end
                if (count == GEN_CYCLES - 7'h01) begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                end
            end
        end
    end

endmodule // rollcode_cipher
`default_nettype wire

// ===== core/tag_pin_mode_and_rollcode.sv
// Tag core: page memory, detect pin modes and rolling code control
//
// Function
// - field detect mode drives the pin
// - tamper mode leaves pin undriven, input
// - pin low before field enters sleep
// - field mode: open drain or 1.8V push-pull
// - pin function and type from config page
// - generator uses key and timestamp from memory
// - rolling code is timestamp plus random word
// - generate only when rollcode enable set
// - mix disabled: key and timestamp only
// - mix enabled: tamper status joins calculation
// - push-pull pin level follows RF field presence; open drain pulls low
// - tamper mode records pin level in memory
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module tag_pin_mode_and_rollcode
    import tag_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    // Register port
    input  wire logic [5:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_write,
    input  wire logic        i_read,
    output logic [31:0]      o_rdata,
    // Analog front end
    input  wire logic        i_rf_field,
    // Field detect pin
    input  wire logic        i_field_detect_pin_in,
    output logic             o_field_detect_pin_out,
    output logic             o_field_detect_pin_oe_n,
    // Status
    output logic             o_sleep,
    output logic [63:0]      o_rolling_code_word,
    output logic             o_rollcode_busy
);

    // ==========================================================
    // Storage
    logic [31:0] nvm [0:NVM_PAGES-1];
    logic [31:0] time_stamp_word;
    logic [31:0] pseudo_random_word;

    // ==========================================================
    // Decoded configuration
    logic [7:0]  detect_pin_config;
    logic [7:0]  dynamic_data_config;
    logic [7:0]  tamper_data_low;
    pin_mode_e   pin_mode;
    logic        pin_push_pull;
    logic        rollcode_gen_enable;
    logic        tamper_mix_enable;
    logic [79:0] cipher_key;

    assign detect_pin_config   =
        nvm[PAGE_CONFIG_B][DETECT_CFG_LSB +: 8];
    assign dynamic_data_config =
        nvm[PAGE_CONFIG_B][DYN_CFG_LSB +: 8];
    assign tamper_data_low     =
        nvm[PAGE_CONFIG_A][TAMPER_LOW_LSB +: 8];
    assign pin_mode            =
        pin_mode_e'(detect_pin_config[PIN_FUNC_LSB +: 2]);
    assign pin_push_pull       =
        detect_pin_config[PIN_PUSHPULL_BIT];
    assign rollcode_gen_enable = dynamic_data_config[ROLL_EN_BIT];
    assign tamper_mix_enable   = dynamic_data_config[MIX_EN_BIT];
    assign cipher_key          = {nvm[PAGE_KEY_HIGH],
                                  nvm[PAGE_KEY_MID],
                                  nvm[PAGE_KEY_LOW][31:16]};

    // ==========================================================
    // Pin stage
    logic pin_level;

    detect_pin_port u_pin (
        .i_clk       (i_clk),
        .i_reset_n   (i_reset_n),
        .i_mode      (pin_mode),
        .i_push_pull (pin_push_pull),
        .i_rf_field  (i_rf_field),
        .i_pin_in    (i_field_detect_pin_in),
        .o_pin_out   (o_field_detect_pin_out),
        .o_pin_oe_n  (o_field_detect_pin_oe_n),
        .o_pin_level (pin_level)
    );

    // ==========================================================
    // Field edges
    logic field_q;
    logic field_rise;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            field_q <= 1'b0;
        end else begin
            field_q <= i_rf_field;
        end
    end

    assign field_rise = i_rf_field && !field_q;

    // ==========================================================
    // Sleep strap
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sleep <= 1'b0;
        end else if (!i_rf_field) begin
            o_sleep <= 1'b0;
        end else if (field_rise && pin_mode == PIN_SLEEP_STRAP
                     && !pin_level) begin
            o_sleep <= 1'b1;
        end
    end

    // ==========================================================
    // Tamper recording
    logic [7:0] tamper_now;
    logic       tamper_update;

    assign tamper_now    = pin_level ? TAMPER_OPEN : TAMPER_CLOSED;
    assign tamper_update = (pin_mode == PIN_TAMPER_DETECT)
                        && (tamper_now != tamper_data_low);

    // ==========================================================
    // Rolling code control
    typedef enum logic [1:0] {
        GEN_IDLE,
        GEN_START,
        GEN_RUN
    } gen_state_e;

    gen_state_e  gen_state;
    gen_state_e  next_gen_state;
    logic        gen_start;
    logic        gen_busy;
    logic        gen_done;
    logic [31:0] gen_word;
    logic        stamp_bump;

    // New code on each field arrival while enabled and the generator is idle
    assign stamp_bump = (gen_state == GEN_IDLE) && field_rise
                     && rollcode_gen_enable;
    assign gen_start  = (gen_state == GEN_START);

    always_comb begin
        next_gen_state = gen_state;
        case (gen_state)
            GEN_IDLE: begin
                if (stamp_bump) begin
                    next_gen_state = GEN_START;
                end
            end
            GEN_START: begin
                next_gen_state = GEN_RUN;
            end
            GEN_RUN: begin
                if (gen_done) begin
                    next_gen_state = GEN_IDLE;
                end
            end
            default: begin
                next_gen_state = GEN_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            gen_state <= GEN_IDLE;
        end else begin
            gen_state <= next_gen_state;
        end
    end

    rollcode_cipher u_cipher (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_start   (gen_start),
        .i_key     (cipher_key),
        .i_stamp   (time_stamp_word),
        .i_tamper  (tamper_data_low),
        .i_mix     (tamper_mix_enable),
        .o_busy    (gen_busy),
        .o_done    (gen_done),
        .o_word    (gen_word)
    );

    assign o_rollcode_busy = (gen_state != GEN_IDLE);

    // ==========================================================
    // Timestamp: hardware increment wins over software write
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            time_stamp_word <= PAGE_RESET;
        end else if (stamp_bump) begin
            time_stamp_word <= time_stamp_word + 32'h0000_0001;
        end else if (i_write && i_addr == PAGE_TIME_STAMP) begin
            time_stamp_word <= i_wdata;
        end
    end

    // ==========================================================
    // Random word and rolling code
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pseudo_random_word  <= PAGE_RESET;
            o_rolling_code_word <= '0;
        end else if (gen_done && gen_state == GEN_RUN) begin
            pseudo_random_word  <= gen_word;
            o_rolling_code_word <= {time_stamp_word, gen_word};
        end
    end

    // ==========================================================
    // Page memory
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int i = 0; i < NVM_PAGES; i++) begin
                nvm[i] <= PAGE_RESET;
            end
            nvm[PAGE_UID_HEAD] <= UID_HEAD_VAL;
            nvm[PAGE_UID_TAIL] <= UID_TAIL_VAL;
        end else begin
            if (i_write && i_addr >= PAGE_UID_CHECK
                && i_addr <= PAGE_INIT_VECTOR) begin
                nvm[i_addr] <= i_wdata;
            end
            // Recorded tamper state overrides a same-cycle write
            if (tamper_update) begin
                nvm[PAGE_CONFIG_A][TAMPER_LOW_LSB +: 8] <= tamper_now;
            end
        end
    end

    // ==========================================================
    // Read port
    logic [31:0] core_status;

    assign core_status = {24'h00_0000,
                          2'b00,
                          tamper_data_low[0],
                          gen_busy,
                          o_sleep,
                          pin_level,
                          pin_mode};

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= '0;
        end else if (i_read) begin
            case (i_addr)
                PAGE_ACCESS_SECRET,
                PAGE_ACCESS_ACK,
                PAGE_KEY_HIGH,
                PAGE_KEY_MID,
                PAGE_KEY_LOW: begin
                    o_rdata <= '0;
                end
                PAGE_TIME_STAMP: begin
                    o_rdata <= time_stamp_word;
                end
                PAGE_PSEUDO_RANDOM: begin
                    o_rdata <= pseudo_random_word;
                end
                PAGE_CORE_STATUS: begin
                    o_rdata <= core_status;
                end
                default: begin
                    if (i_addr <= PAGE_INIT_VECTOR) begin
                        o_rdata <= nvm[i_addr];
                    end else begin
                        o_rdata <= '0;
                    end
                end
            endcase
        end else begin
            o_rdata <= '0;
        end
    end

endmodule // tag_pin_mode_and_rollcode
`default_nettype wire

// ===== tb/rf_reader_model.sv
// Reader field and pad circuit around the detect pin
`timescale 1ns/10ps
`default_nettype none
module rf_reader_model (
    // Commands from the bench
    input  wire logic i_field_on,
    input  wire logic i_ext_drive,
    input  wire logic i_ext_level,
    // Core side of the pad
    input  wire logic i_pin_out,
    input  wire logic i_pin_oe_n,
    output logic      o_rf_field,
    output logic      o_pin_level
);
    assign o_rf_field = i_field_on;
    // Pull-up holds the pad high when nobody drives; an external drive forces i_ext_level only while the core releases the pin
    assign o_pin_level = !i_pin_oe_n ? i_pin_out :
                         i_ext_drive ? i_ext_level : 1'b1;
endmodule // rf_reader_model
`default_nettype wire

// ===== tb/tag_pin_mode_and_rollcode_monitor.sv
// Port checker of the tag core and its bind
`timescale 1ns/10ps
`default_nettype none
module tag_core_monitor (
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_reset_n,
    // Ports watched
    input wire logic        i_read,
    input wire logic [31:0] o_rdata,
    input wire logic        i_rf_field,
    input wire logic        o_field_detect_pin_out,
    input wire logic        o_field_detect_pin_oe_n,
    input wire logic        o_sleep,
    input wire logic [63:0] o_rolling_code_word,
    input wire logic        o_rollcode_busy
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);
    // ====================================================
    // Properties
    property p_rdata_quiet;
        !$past(i_read) |-> o_rdata == 32'h0;
    endproperty
    a_rdata_quiet: assert property (p_rdata_quiet)
        else $error("read data outside answer cycle");
    property p_out_driven;
        o_field_detect_pin_out |-> !o_field_detect_pin_oe_n;
    endproperty
    a_out_driven: assert property (p_out_driven)
        else $error("pin high value while released");
    property p_out_field;
        o_field_detect_pin_out |-> $past(i_rf_field);
    endproperty
    a_out_field: assert property (p_out_field)
        else $error("pin high without field");
    property p_sleep_rise;
        $rose(o_sleep) |-> $past(i_rf_field) && !$past(i_rf_field, 2);
    endproperty
    a_sleep_rise: assert property (p_sleep_rise)
        else $error("sleep entered without field arrival");
    property p_sleep_clear;
        !i_rf_field |=> !o_sleep;
    endproperty
    a_sleep_clear: assert property (p_sleep_clear)
        else $error("sleep kept without field");
    property p_busy_start;
        $rose(o_rollcode_busy) |-> $past(i_rf_field) && !$past(i_rf_field, 2);
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("generator started without field arrival");
    property p_busy_hold;
        $rose(o_rollcode_busy) |=> o_rollcode_busy [*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("generator stopped early");
    property p_busy_end;
        $rose(o_rollcode_busy) |-> ##[90:110] !o_rollcode_busy;
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("generator run length wrong");
    property p_code_hold;
        $changed(o_rolling_code_word)
            |-> $past(o_rollcode_busy) || $past(o_rollcode_busy, 2);
    endproperty
    a_code_hold: assert property (p_code_hold)
        else $error("rolling code changed without a run");
    c_sleep: cover property ($rose(o_sleep));
    c_busy: cover property ($rose(o_rollcode_busy));
    c_drive: cover property (o_field_detect_pin_out);
endmodule // tag_core_monitor

bind tag_pin_mode_and_rollcode tag_core_monitor tag_core_monitor_inst (
    .i_clk                   (i_clk),
    .i_reset_n               (i_reset_n),
    .i_read                  (i_read),
    .o_rdata                 (o_rdata),
    .i_rf_field              (i_rf_field),
    .o_field_detect_pin_out  (o_field_detect_pin_out),
    .o_field_detect_pin_oe_n (o_field_detect_pin_oe_n),
    .o_sleep                 (o_sleep),
    .o_rolling_code_word     (o_rolling_code_word),
    .o_rollcode_busy         (o_rollcode_busy)
);
`default_nettype wire

// ===== tb/test_tag_pin_mode_and_rollcode.sv
// Self-checking bench of the tag core
`timescale 1ns/10ps
`default_nettype none
module test_tag_pin_mode_and_rollcode import tag_pkg::*; ();
    logic        i_clk = 1'b0;
    logic        i_reset_n = 1'b0;
    logic [5:0]  i_addr = 6'h00;
    logic [31:0] i_wdata = 32'h0;
    logic        i_write = 1'b0;
    logic        i_read = 1'b0;
    logic        field_on = 1'b0;
    logic        ext_drive = 1'b0;
    logic        ext_level = 1'b0;
    logic        rf_field;
    logic        pin_level;
    logic [31:0] o_rdata;
    logic        pin_out;
    logic        pin_oe_n;
    logic        o_sleep;
    logic [63:0] o_rolling_code_word;
    logic        o_rollcode_busy;
    logic [31:0] mem [$];
    int          n_mismatch = 0;
    int          cmp_count = 0;

    always #50 i_clk = ~i_clk;

    tag_pin_mode_and_rollcode tag_pin_mode_and_rollcode_inst (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
        .o_rdata(o_rdata), .i_rf_field(rf_field),
        .i_field_detect_pin_in(pin_level),
        .o_field_detect_pin_out(pin_out),
        .o_field_detect_pin_oe_n(pin_oe_n), .o_sleep(o_sleep),
        .o_rolling_code_word(o_rolling_code_word),
        .o_rollcode_busy(o_rollcode_busy));
    rf_reader_model rf_reader_model_inst (
        .i_field_on(field_on), .i_ext_drive(ext_drive),
        .i_ext_level(ext_level), .i_pin_out(pin_out),
        .i_pin_oe_n(pin_oe_n), .o_rf_field(rf_field),
        .o_pin_level(pin_level));

    // ====================================================
    // Tasks
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_write <= 1'b1;
        @(posedge i_clk);
        i_write <= 1'b0;
    endtask
    task automatic rchk(input logic [5:0] a, input logic [31:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_read <= 1'b1;
        @(posedge i_clk);
        i_read <= 1'b0;
        @(negedge i_clk);
        chk(64'(o_rdata), 64'(e));
    endtask
    function automatic logic [31:0] cfg(input int md, pp, en, mx);
        cfg = 32'(md) << (DETECT_CFG_LSB + PIN_FUNC_LSB)
            | 32'(pp) << (DETECT_CFG_LSB + PIN_PUSHPULL_BIT)
            | 32'(en) << (DYN_CFG_LSB + ROLL_EN_BIT)
            | 32'(mx) << (DYN_CFG_LSB + MIX_EN_BIT);
    endfunction
    task automatic gen(input logic [31:0] st, output logic [31:0] w);
        int n;
        wr(PAGE_TIME_STAMP, st);
        field_on <= 1'b0;
        cyc(3);
        field_on <= 1'b1;
        cyc(3);
        n = 0;
        while (o_rollcode_busy !== 1'b0 && n < 300) begin
            @(negedge i_clk);
            n++;
        end
        if (n == 300) begin
            n_mismatch++;
            give_verdict();
        end
        cyc(2);
        @(negedge i_clk);
        chk(64'(o_rolling_code_word[63:32]), 64'(st + 32'h1));
        w = o_rolling_code_word[31:0];
        rchk(PAGE_TIME_STAMP, st + 32'h1);
        rchk(PAGE_PSEUDO_RANDOM, w);
        @(posedge i_clk);
    endtask

    // ====================================================
    // Main sequence
    initial begin
        logic [31:0] w0, w1, w2, w3, w4, d;
        logic [63:0] code;
        int m, p, f;
        d = $urandom(32'h8777);
        cyc(4);
        i_reset_n <= 1'b1;
        rchk(PAGE_UID_HEAD, UID_HEAD_VAL);
        rchk(PAGE_CONFIG_B, PAGE_RESET);
        for (p = 4; p < 40; p += 5) begin
            mem.push_back($urandom);
            wr(6'(p), mem[mem.size() - 1]);
        end
        for (p = 0; p < 8; p++) rchk(6'(4 + 5 * p), mem[p]);
        wr(PAGE_UID_HEAD, 32'hFFFF_FFFF);
        wr(PAGE_KEY_HIGH, 32'h1234_5678);
        rchk(PAGE_UID_HEAD, UID_HEAD_VAL);
        rchk(PAGE_KEY_HIGH, 32'h0);
        rchk(6'h3F, 32'h0);
        $display("test registers done");
        for (m = 0; m < 4; m++)
            for (p = 0; p < 2; p++)
                for (f = 0; f < 2; f++) begin
                    wr(PAGE_CONFIG_B, cfg(m, p, 0, 0));
                    field_on <= f[0];
                    cyc(3);
                    @(negedge i_clk);
                    chk(64'(pin_oe_n), 64'(m != 1 || p + f == 0));
                    chk(64'(pin_out), 64'(m == 1 && p == 1 && f == 1));
                end
        $display("test pin modes done");
        wr(PAGE_CONFIG_B, cfg(2, 0, 0, 0));
        for (p = 0; p < 2; p++) begin
            @(posedge i_clk);
            ext_drive <= 1'b1;
            ext_level <= p[0];
            cyc(3);
            rchk(PAGE_CONFIG_A,
                32'(p ? TAMPER_OPEN : TAMPER_CLOSED) << TAMPER_LOW_LSB);
        end
        $display("test tamper done");
        wr(PAGE_CONFIG_B, cfg(3, 0, 0, 0));
        for (p = 0; p < 2; p++) begin
            @(posedge i_clk);
            ext_level <= p[0];
            field_on <= 1'b0;
            cyc(3);
            @(negedge i_clk);
            chk(64'(o_sleep), 64'h0);
            @(posedge i_clk);
            field_on <= 1'b1;
            cyc(3);
            @(negedge i_clk);
            chk(64'(o_sleep), 64'(p == 0));
        end
        // Status: tamper open, awake, pin high, strap mode
        rchk(PAGE_CORE_STATUS, 32'h0000_0027);
        $display("test sleep done");
        for (p = 0; p < 3; p++) wr(PAGE_KEY_HIGH + 6'(p), $urandom);
        ext_level <= 1'b0;
        wr(PAGE_CONFIG_B, cfg(2, 0, 1, 0));
        gen(d, w0);
        ext_level <= 1'b1;
        gen(d, w1);
        chk(64'(w1), 64'(w0));
        wr(PAGE_CONFIG_B, cfg(2, 0, 1, 1));
        gen(d, w2);
        ext_level <= 1'b0;
        gen(d, w3);
        chk(64'(w2 != w3), 64'h1);
        wr(PAGE_KEY_HIGH, ~w3);
        gen(d, w4);
        chk(64'(w4 != w3), 64'h1);
        $display("test rolling code done");
        wr(PAGE_CONFIG_B, cfg(2, 0, 0, 1));
        code = o_rolling_code_word;
        field_on <= 1'b0;
        cyc(3);
        field_on <= 1'b1;
        cyc(120);
        @(negedge i_clk);
        chk(o_rolling_code_word, code);
        chk(64'(o_rollcode_busy), 64'h0);
        rchk(PAGE_TIME_STAMP, d + 32'h1);
        $display("test disabled generator done");
        give_verdict();
    end
endmodule // test_tag_pin_mode_and_rollcode
`default_nettype wire
